// ==== tb/mws_checker.sv ====
// Port checker for the write-multiple slave.
// Assumes binding to every mws_slave instance.
`timescale 1ns/100ps
module mws_checker
#(
  parameter int N_DO = 16,
  parameter int N_AO = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Streams
  input wire logic rx_valid,
  input wire logic rx_start,
  input wire logic [7:0] rx_byte,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [7:0] tx_byte,
  // Master side and outputs
  input wire logic hires_variant,
  input wire logic mst_rsp_valid,
  input wire logic [7:0] mst_rsp_func,
  input wire logic [7:0] mst_rsp_exc,
  input wire logic [15:0] mst_req_qty,
  input wire logic mst_qty_ok_q,
  input wire logic [7:0] response_function_query,
  input wire logic [7:0] exception_code_query,
  input wire logic [N_DO-1:0] dout_q,
  input wire logic [N_AO*16-1:0] aout_q
);
  logic [1:0] rel_q;
  logic [7:0] func_q;
  logic over;
  // Skip the cycles of the reset synchroniser
  always_ff @(posedge mclk or negedge nrst)
    if (!nrst) rel_q <= 2'h0;
    else if (rel_q != 2'h3) rel_q <= rel_q + 2'h1;
  always_ff @(posedge mclk)
    if (rx_valid && rx_start) func_q <= rx_byte;
  always_comb
  begin
    over = 1'b0;
    for (int g = 0; g < N_AO; g++)
      if (aout_q[16*g+:16] > 16'hfff0) over = 1'b1;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (rel_q != 2'h3);
  property p_qty;
    mst_qty_ok_q == ($past(mst_req_qty) inside {[16'h0001:16'h007b]});
  endproperty
  a_qty: assert property (p_qty) else $error("quantity flag wrong");
  property p_func;
    mst_rsp_valid |-> ##[1:2] response_function_query == mst_rsp_func;
  endproperty
  a_func: assert property (p_func) else $error("reply code not kept");
  property p_exc;
    mst_rsp_valid |-> ##[1:2] exception_code_query == (mst_rsp_func[7] ? mst_rsp_exc : 8'h00);
  endproperty
  a_exc: assert property (p_exc) else $error("exception code not kept");
  property p_code;
    tx_valid && !$past(tx_valid) |-> tx_byte == func_q || tx_byte == (func_q | 8'h80);
  endproperty
  a_code: assert property (p_code) else $error("reply code wrong");
  property p_exc_len;
    tx_valid && !$past(tx_valid) && tx_byte[7] |=> tx_valid && tx_last;
  endproperty
  a_exc_len: assert property (p_exc_len) else $error("exception reply length");
  property p_echo_len;
    tx_valid && !$past(tx_valid) && !tx_byte[7] |-> (tx_valid && !tx_last)[*4] ##1 tx_last;
  endproperty
  a_echo_len: assert property (p_echo_len) else $error("echo reply length");
  property p_dout;
    !$stable(dout_q) |-> ##[0:4] (tx_valid && tx_byte == 8'h0f);
  endproperty
  a_dout: assert property (p_dout) else $error("outputs changed without echo");
  property p_clamp;
    !hires_variant && $changed(aout_q) |-> !over;
  endproperty
  a_clamp: assert property (p_clamp) else $error("count above base limit");
endmodule // mws_checker
bind mws_slave mws_checker #(.N_DO(N_DO), .N_AO(N_AO)) u_chk (.mclk, .nrst, .rx_valid,
  .rx_start, .rx_byte, .tx_valid, .tx_last, .tx_byte, .hires_variant, .mst_rsp_valid,
  .mst_rsp_func, .mst_rsp_exc, .mst_req_qty, .mst_qty_ok_q, .response_function_query,
  .exception_code_query, .dout_q, .aout_q);

// ==== tb/mws_master_model.sv ====
// Remote master model: sends request frames as a byte stream.
// Assumes the slave takes one byte per rising mclk with rx_valid.
`timescale 1ns/100ps
module mws_master_model
(
  // Clock
  input wire logic mclk,
  // Request stream
  output logic rx_valid = 1'b0,
  output logic rx_start = 1'b0,
  output logic [7:0] rx_byte = 8'h00
);
  logic [7:0] fr[$];
  // Idle line shows the inverse of the last byte
  task automatic send();
    for (int i = 0; i < fr.size(); i++)
    begin
      @(posedge mclk);
      rx_valid <= 1'b1;
      rx_start <= (i == 0);
      rx_byte <= fr[i];
    end
    @(posedge mclk);
    rx_valid <= 1'b0;
    rx_start <= 1'b0;
    rx_byte <= ~fr[fr.size()-1];
  endtask
  task automatic head(input logic [7:0] fc, input logic [15:0] a, q);
    fr = '{fc, a[15:8], a[7:0], q[15:8], q[7:0]};
  endtask
  task automatic coils(input logic [15:0] a, q, v);
    head(8'h0f, a, q);
    fr.push_back((q > 16'h0008) ? 8'h02 : 8'h01);
    fr.push_back(v[7:0]);
    if (q > 16'h0008) fr.push_back(v[15:8]);
    send();
  endtask
  task automatic bad_code(input logic [7:0] fc);
    head(fc, 16'h0000, 16'h0001);
    fr.push_back(8'h01);
    fr.push_back(8'h01);
    send();
  endtask
  task automatic regs(input logic [15:0] a, input logic [15:0] w[$]);
    head(8'h10, a, 16'(w.size()));
    fr.push_back(8'(2 * w.size()));
    foreach (w[i])
    begin
      fr.push_back(w[i][15:8]);
      fr.push_back(w[i][7:0]);
    end
    send();
  endtask
endmodule // mws_master_model

// ==== tb/testbench.sv ====
// Self-checking bench for the write-multiple slave.
// Assumes the master model drives the request stream.
`timescale 1ns/100ps
module testbench;
  logic mclk, nrst, rx_valid, rx_start, tx_valid, tx_last, mst_rsp_valid, mst_qty_ok_q;
  logic register_format_select, hires_variant;
  logic [7:0] rx_byte, tx_byte, mst_rsp_func, mst_rsp_exc;
  logic [7:0] response_function_query, exception_code_query;
  logic [15:0] mst_req_qty, dout_q;
  logic [127:0] aout_q;
  logic [255:0] aout_float_q;
  int n_fail = 0;
  int compares = 0;
  mws_slave u_dut (.mclk, .nrst, .rx_valid, .rx_start, .rx_byte, .tx_valid, .tx_last,
    .tx_byte, .register_format_select, .hires_variant, .mst_rsp_valid, .mst_rsp_func,
    .mst_rsp_exc, .mst_req_qty, .mst_qty_ok_q, .response_function_query,
    .exception_code_query, .dout_q, .aout_q, .aout_float_q);
  mws_master_model u_mst (.mclk, .rx_valid, .rx_start, .rx_byte);
  initial
  begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end
  task automatic chk(input logic [255:0] got, exp, input string m);
    compares++;
    if (got !== exp)
    begin
      n_fail++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic reply(input logic [7:0] e[$]);
    for (int n = 0; n < 40 && tx_valid !== 1'b1; n++) @(negedge mclk);
    foreach (e[i])
    begin
      chk(tx_byte, e[i], "reply byte");
      chk(tx_last, i == e.size() - 1, "reply end");
      @(negedge mclk);
    end
  endtask
  task automatic end_of_test();
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic t_coils();
    u_mst.coils(16'h0000, 16'h0010, 16'h55aa);
    reply('{8'h0f, 8'h00, 8'h00, 8'h00, 8'h10});
    chk(dout_q, 16'h55aa, "coils all");
    u_mst.coils(16'h0004, 16'h0003, 16'h0005);
    reply('{8'h0f, 8'h00, 8'h04, 8'h00, 8'h03});
    chk(dout_q, 16'h55da, "coils part");
    u_mst.coils(16'h000f, 16'h0002, 16'h0003);
    reply('{8'h8f, 8'h02});
    chk(dout_q, 16'h55da, "coils refused");
    u_mst.coils(16'hffff, 16'h0002, 16'h0003);
    reply('{8'h8f, 8'h02});
    chk(dout_q, 16'h55da, "coils wrapped");
    u_mst.bad_code(8'h05);
    reply('{8'h85, 8'h01});
    chk(dout_q, 16'h55da, "code refused");
  endtask
  task automatic t_float();
    u_mst.regs(16'h0002, '{16'h40a0, 16'h0000, 16'h4040, 16'h0000});
    reply('{8'h10, 8'h00, 8'h02, 8'h00, 8'h04});
    chk(aout_float_q[63:32], 32'h40a00000, "float ch1");
    chk(aout_float_q[95:64], 32'h40400000, "float ch2");
    u_mst.regs(16'h0000, '{16'h1234, 16'h5678});
    reply('{8'h90, 8'h02});
    chk(aout_float_q[31:0], 32'h0, "float refused");
  endtask
  task automatic t_count();
    @(posedge mclk);
    register_format_select <= 1'b1;
    u_mst.regs(16'h0002, '{16'hffff, 16'h9999});
    reply('{8'h10, 8'h00, 8'h02, 8'h00, 8'h02});
    chk(aout_q[47:32], 16'hfff0, "base clamp");
    chk(aout_q[63:48], 16'h9999, "count ch3");
    u_mst.regs(16'h0007, '{16'h0001, 16'h0002});
    reply('{8'h90, 8'h02});
    chk(aout_q[127:112], 16'h0, "count refused");
    @(posedge mclk);
    hires_variant <= 1'b1;
    u_mst.regs(16'h0007, '{16'hffff});
    reply('{8'h10, 8'h00, 8'h07, 8'h00, 8'h01});
    chk(aout_q[127:112], 16'hffff, "full scale");
  endtask
  task automatic t_master();
    logic [15:0] q[4] = '{16'h0000, 16'h0001, 16'h007b, 16'h007c};
    logic [7:0] f[3] = '{8'h10, 8'h90, 8'h8f};
    logic [7:0] x[3] = '{8'h01, 8'h01, 8'h02};
    foreach (q[i])
    begin
      @(posedge mclk);
      mst_req_qty <= q[i];
      @(posedge mclk);
      @(negedge mclk);
      chk(mst_qty_ok_q, q[i] inside {[1:123]}, "qty limit");
    end
    foreach (f[i])
    begin
      @(posedge mclk);
      mst_rsp_valid <= 1'b1;
      mst_rsp_func <= f[i];
      mst_rsp_exc <= x[i];
      @(posedge mclk);
      mst_rsp_valid <= 1'b0;
      @(posedge mclk);
      @(negedge mclk);
      chk(response_function_query, f[i], "reply code");
      chk(exception_code_query, f[i][7] ? x[i] : 8'h00, "exc code");
    end
  endtask
  initial
  begin
    nrst = 1'b0;
    register_format_select = 1'b0;
    hires_variant = 1'b0;
    mst_rsp_valid = 1'b0;
    mst_rsp_func = 8'h00;
    mst_rsp_exc = 8'h00;
    mst_req_qty = 16'h0000;
    repeat (3) @(posedge mclk);
    nrst <= 1'b1;
    repeat (3) @(posedge mclk);
    t_coils();
    t_float();
    t_count();
    t_master();
    end_of_test();
  end
  // About 170 cycles expected
  initial
  begin
    #100us;
    n_fail++;
    end_of_test();
  end
endmodule // testbench

// ==== verilog/mws_out_chan.sv ====
// One analog output holding register with range clamp per variant.
// Assumes a write strobe with a full 16-bit value already assembled.
`timescale 1ns/100ps
`include "mws_regs.svh"
module mws_out_chan
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_n,
  // Write side
  input wire logic wr_en,
  input wire logic [15:0] wr_val,
  input wire logic hires,
  // Output
  output logic [15:0] val_q
);
  logic [15:0] val_d;
  wire logic over_base = wr_val > `MWS_DAC_BASE_MAX;
  // Base variant tops out below full scale
  assign val_d = (!hires && over_base) ? `MWS_DAC_BASE_MAX : wr_val; // see R11 R12
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      val_q <= 16'h0000;
    else if (wr_en)
      val_q <= val_d; // see R07
  end
endmodule // mws_out_chan

// ==== verilog/mws_pkg.sv ====
// Types for the write-multiple slave.
// Assumes mws_regs.svh holds all numeric constants.
package mws_pkg;
  typedef enum logic [3:0] {
    MWS_IDLE = 4'h0,
    MWS_ADDR_H = 4'h1,
    MWS_ADDR_L = 4'h2,
    MWS_QTY_H = 4'h3,
    MWS_QTY_L = 4'h4,
    MWS_BCNT = 4'h5,
    MWS_DATA = 4'h6,
    MWS_RESP = 4'h7,
    MWS_SKIP = 4'h8
  } mws_state_t;
  typedef enum logic [1:0] {
    MWS_TX_ECHO = 2'h0,
    MWS_TX_EXC = 2'h1
  } mws_tx_kind_t;
endpackage

// ==== verilog/mws_regs.svh ====
// Constants for the write-multiple slave: function codes, address windows, limits.
// Assumes inclusion by bare name from design files.
`ifndef MWS_REGS_SVH
`define MWS_REGS_SVH
`define MWS_FC_WR_COILS 8'h0f
`define MWS_FC_WR_REGS 8'h10
`define MWS_FC_EXC_BIT 8'h80
`define MWS_EXC_ILL_FUNC 8'h01
`define MWS_EXC_ILL_ADDR 8'h02
`define MWS_COIL_MAX 16'h0010
`define MWS_FLT_FIRST 16'h0001
`define MWS_FLT_LAST 16'h000e
`define MWS_CNT_FIRST 16'h0000
`define MWS_CNT_LAST 16'h0007
`define MWS_MASTER_MAX_REGS 16'h007b
`define MWS_DAC_BASE_MAX 16'hfff0
`define MWS_ADC_BASE_MAX 16'h7f3c
`endif

// ==== verilog/mws_slave.sv ====
// Modbus slave core for write-multiple-coils and write-multiple-registers.
// Assumes a byte stream per frame (rx_start marks the function byte) and a ready sink.
// Function
// R01: Coil request: code, address, quantity, count, data
// R02: Coil n drives output n, LSB first
// R03: Echo code, address, quantity; up to 16
// R04: Float format accepts registers 1 through 14
// R05: Count format accepts registers 0 through 7
// R06: Register reply echoes code, address, quantity
// R07: Register mapping per format updates outputs
// R08: Float sent high word first
// R09: Master request limited to 123 registers
// R10: Master records reply code and exception code
// R11: Base variant output counts 0 to 65520
// R12: High-resolution variant count ranges
// R13: Out-of-range request gets exception, no change
`timescale 1ns/100ps
`include "mws_regs.svh"
module mws_slave
#(
  parameter int N_DO = 16,
  parameter int N_AO = 8
)
(
  // Clock and reset
  input wire logic mclk,
  input wire logic nrst,
  // Request byte stream
  input wire logic rx_valid,
  input wire logic rx_start,
  input wire logic [7:0] rx_byte,
  // Response byte stream
  output logic tx_valid,
  output logic tx_last,
  output logic [7:0] tx_byte,
  // Configuration
  input wire logic register_format_select,
  input wire logic hires_variant,
  // Master side: reply observed from a remote slave
  input wire logic mst_rsp_valid,
  input wire logic [7:0] mst_rsp_func,
  input wire logic [7:0] mst_rsp_exc,
  input wire logic [15:0] mst_req_qty,
  output logic mst_qty_ok_q,
  output logic [7:0] response_function_query,
  output logic [7:0] exception_code_query,
  // Outputs
  output logic [N_DO-1:0] dout_q,
  output logic [N_AO*16-1:0] aout_q,
  output logic [N_AO*32-1:0] aout_float_q
);
  import mws_pkg::*;
  if (N_DO != 16 || N_AO != 8)
  begin : g_bad_size
    $error("mws_slave: only 16 outputs and 8 analog channels are served");
  end
  logic rs1_q, rst_n;
  always_ff @(posedge mclk or negedge nrst)
  begin
    if (!nrst)
    begin
      rs1_q <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rs1_q <= 1'b1;
      rst_n <= rs1_q;
    end
  end
  mws_state_t st_q, st_d;
  logic [7:0] func_q;
  logic [15:0] addr_q, qty_q;
  logic [7:0] bcnt_q, idx_q;
  logic bad_q;
  logic [7:0] exc_q;
  logic [2:0] tx_idx_q;
  logic [15:0] coil_q;
  logic [15:0] coil_mask_q;
  logic [15:0] rword_q [0:15];
  logic [15:0] wr_mask_q;
  logic commit_q;
  wire logic in_byte = rx_valid && !rx_start;
  wire logic is_coil = func_q == `MWS_FC_WR_COILS;
  wire logic is_reg = func_q == `MWS_FC_WR_REGS;
  wire logic [15:0] last_addr = addr_q + qty_q - 16'h0001;
  // A window that runs past the top of the address space wraps below its start
  wire logic no_wrap = last_addr >= addr_q; // see R13
  wire logic coil_ok = qty_q != 16'h0000 && qty_q <= `MWS_COIL_MAX && no_wrap
    && last_addr < `MWS_COIL_MAX; // see R03
  wire logic flt_ok = qty_q != 16'h0000 && addr_q >= `MWS_FLT_FIRST && no_wrap
    && last_addr <= `MWS_FLT_LAST; // see R04
  wire logic cnt_ok = qty_q != 16'h0000 && last_addr <= `MWS_CNT_LAST && no_wrap
    && addr_q <= `MWS_CNT_LAST; // see R05
  wire logic reg_ok = register_format_select ? cnt_ok : flt_ok;
  wire logic range_ok = is_coil ? coil_ok : reg_ok;
  wire logic [15:0] byte_pos = {8'h00, idx_q};
  wire logic [3:0] reg_slot = 4'(addr_q + {9'h000, idx_q[7:1]});
  wire logic [3:0] coil_slot = 4'({idx_q, 3'h0} + addr_q);
  // Coils are packed from the start address upward, LSB first
  wire logic [31:0] coil_shift = {16'h0000, 8'h00, rx_byte} << coil_slot; // see R02
  wire logic [15:0] coil_bits = coil_shift[15:0];
  always_comb
  begin
    st_d = st_q;
    case (st_q)
      MWS_IDLE: if (rx_valid && rx_start) st_d = MWS_ADDR_H;
      MWS_ADDR_H: if (in_byte) st_d = MWS_ADDR_L;
      MWS_ADDR_L: if (in_byte) st_d = MWS_QTY_H;
      MWS_QTY_H: if (in_byte) st_d = MWS_QTY_L;
      MWS_QTY_L: if (in_byte) st_d = MWS_BCNT; // see R01
      MWS_BCNT: if (in_byte) st_d = (rx_byte == 8'h00) ? MWS_RESP : MWS_DATA;
      MWS_DATA: if (in_byte && byte_pos + 16'h0001 == {8'h00, bcnt_q}) st_d = MWS_RESP;
      MWS_RESP: if (tx_last) st_d = MWS_IDLE;
      MWS_SKIP: if (tx_last) st_d = MWS_IDLE;
      default: st_d = MWS_IDLE;
    endcase
    if (st_q != MWS_IDLE && st_q != MWS_RESP && st_q != MWS_SKIP && rx_valid && rx_start)
      st_d = MWS_ADDR_H;
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st_q <= MWS_IDLE;
      func_q <= 8'h00;
      addr_q <= 16'h0000;
      qty_q <= 16'h0000;
      bcnt_q <= 8'h00;
      idx_q <= 8'h00;
    end
    else
    begin
      st_q <= st_d;
      if (rx_valid && rx_start)
      begin
        func_q <= rx_byte;
        idx_q <= 8'h00;
      end
      if (in_byte)
      begin
        case (st_q)
          MWS_ADDR_H: addr_q[15:8] <= rx_byte;
          MWS_ADDR_L: addr_q[7:0] <= rx_byte;
          MWS_QTY_H: qty_q[15:8] <= rx_byte;
          MWS_QTY_L: qty_q[7:0] <= rx_byte;
          MWS_BCNT: bcnt_q <= rx_byte;
          MWS_DATA: idx_q <= idx_q + 8'h01;
          default: bcnt_q <= bcnt_q;
        endcase
      end
    end
  end
  // Staging: collect words, commit only once the frame is whole and legal
  wire logic stage_wr = in_byte && st_q == MWS_DATA && !bad_q;
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      bad_q <= 1'b0;
      exc_q <= 8'h00;
      coil_q <= 16'h0000;
      coil_mask_q <= 16'h0000;
      wr_mask_q <= 16'h0000;
      commit_q <= 1'b0;
      for (int i = 0; i < 16; i++)
        rword_q[i] <= 16'h0000;
    end
    else
    begin
      commit_q <= 1'b0;
      if (rx_valid && rx_start)
      begin
        bad_q <= 1'b0;
        coil_q <= 16'h0000;
        coil_mask_q <= 16'h0000;
        wr_mask_q <= 16'h0000;
      end
      if (in_byte && st_q == MWS_BCNT)
      begin
        if (!is_coil && !is_reg)
        begin
          bad_q <= 1'b1;
          exc_q <= `MWS_EXC_ILL_FUNC;
        end
        else if (!range_ok)
        begin
          bad_q <= 1'b1; // see R13
          exc_q <= `MWS_EXC_ILL_ADDR;
        end
      end
      if (stage_wr && is_coil && {idx_q, 3'h0} < qty_q)
      begin
        coil_q <= coil_q | coil_bits;
        coil_mask_q <= coil_mask_q | (16'hffff >> (16 - qty_q[4:0])) << addr_q[3:0];
      end
      if (stage_wr && is_reg && {8'h00, idx_q[7:1]} < qty_q)
      begin
        // High byte of each register arrives first
        if (!idx_q[0])
          rword_q[reg_slot][15:8] <= rx_byte;
        else
        begin
          rword_q[reg_slot][7:0] <= rx_byte;
          wr_mask_q[reg_slot] <= 1'b1;
        end
      end
      if (st_q != MWS_RESP && st_d == MWS_RESP && !bad_q && range_ok)
        commit_q <= 1'b1;
    end
  end
  // Coil outputs change only on a legal, complete frame
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
      dout_q <= 16'h0000;
    else if (commit_q && is_coil)
      dout_q <= (dout_q & ~coil_mask_q) | (coil_q & coil_mask_q); // see R02 R13
  end
  genvar g;
  generate
    for (g = 0; g < N_AO; g++)
    begin : g_ao
      // Float: channel g is registers 2g (high word) and 2g+1 (low word)
      wire logic flt_wr = commit_q && is_reg && !register_format_select
        && wr_mask_q[2*g+1]; // see R07 R08
      wire logic cnt_wr = commit_q && is_reg && register_format_select && wr_mask_q[g];
      always_ff @(posedge mclk or negedge rst_n)
      begin
        if (!rst_n)
          aout_float_q[g*32 +: 32] <= 32'h0000_0000;
        else if (flt_wr)
          aout_float_q[g*32 +: 32] <= {rword_q[2*g], rword_q[2*g+1]}; // see R08
      end
      mws_out_chan u_chan
      (
        .mclk(mclk),
        .rst_n(rst_n),
        .wr_en(cnt_wr),
        .wr_val(rword_q[g]),
        .hires(hires_variant),
        .val_q(aout_q[g*16 +: 16])
      );
    end
  endgenerate
  // Reply: echo of code, address, quantity, or code|0x80 plus exception
  wire logic tx_go = st_q == MWS_RESP;
  wire logic tx_exc = bad_q || !range_ok;
  wire logic [2:0] tx_len = tx_exc ? 3'h1 : 3'h4;
  logic [7:0] tx_sel;
  always_comb
  begin
    case (tx_idx_q)
      3'h0: tx_sel = tx_exc ? (func_q | `MWS_FC_EXC_BIT) : func_q; // see R03 R06
      3'h1: tx_sel = tx_exc ? exc_q : addr_q[15:8];
      3'h2: tx_sel = addr_q[7:0];
      3'h3: tx_sel = qty_q[15:8];
      3'h4: tx_sel = qty_q[7:0];
      default: tx_sel = 8'h00;
    endcase
  end
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_idx_q <= 3'h0;
      tx_valid <= 1'b0;
      tx_last <= 1'b0;
      tx_byte <= 8'h00;
    end
    else
    begin
      tx_valid <= tx_go && !tx_last;
      tx_last <= tx_go && !tx_last && tx_idx_q == tx_len;
      tx_byte <= tx_sel;
      tx_idx_q <= (tx_go && !tx_last && tx_idx_q != tx_len) ? tx_idx_q + 3'h1 : 3'h0;
    end
  end
  // Master side bookkeeping
  always_ff @(posedge mclk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mst_qty_ok_q <= 1'b0;
      response_function_query <= 8'h00;
      exception_code_query <= 8'h00;
    end
    else
    begin
      mst_qty_ok_q <= mst_req_qty != 16'h0000 && mst_req_qty <= `MWS_MASTER_MAX_REGS; // see R09
      if (mst_rsp_valid)
      begin
        response_function_query <= mst_rsp_func; // see R10
        exception_code_query <= (mst_rsp_func & `MWS_FC_EXC_BIT) != 8'h00 ? mst_rsp_exc : 8'h00;
      end
    end
  end
endmodule // mws_slave
